// [rtl/cal_store.sv]
// holds one working register; the read port is that register itself
// assumes writes come from the sequencer or the serial decoder, one at a time
`timescale 1ns/1ps
`default_nettype none
module cal_store #(
	parameter int unsigned W = 64
) (
	input wire logic i_clk,        // system clock
	input wire logic i_rst,        // async reset, active high
	input wire logic i_ce,         // clock enable
	input wire logic i_we,         // write strobe
	input wire logic [W-1:0] i_wd, // write data
	output logic [W-1:0] o_rd      // registered contents
);
	logic [W-1:0] mem_q, mem_d;

	always_comb begin
		mem_d = mem_q;
		if (i_we) begin
			mem_d = i_wd;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mem_q <= '0;
		end else if (i_ce) begin
			mem_q <= mem_d;
		end
	end

	assign o_rd = mem_q;
endmodule
`default_nettype wire

// [rtl/por_cal_pkg.sv]
// shared constants and carrier types for the power-on calibration loader
// assumes a 125 MHz system clock; fuse memory and serial decoder sit outside
package por_cal_pkg;
	localparam int unsigned CLK_MHZ = 125;
	// undervoltage must persist longer than this before a new sequence starts
	localparam int unsigned UV_FILTER_NS = 500;
	localparam int unsigned UV_FILTER_CYC = (UV_FILTER_NS * CLK_MHZ) / 1000;
	localparam int unsigned LOAD_PULSES = 188;
	localparam int unsigned OSC_DIV = 4;
	localparam int unsigned DETECT_WINDOW = 64;
	localparam int unsigned DETECT_EDGES = 2;

	localparam int unsigned TRIM_W = 32;
	localparam int unsigned CAL_W = 64;
	localparam int unsigned CFG_W = 16;
	// active gain-100 factor field inside the calibration register
	localparam int unsigned G100_LSB = 0;
	localparam int unsigned G100_W = 16;

	localparam logic [15:0] WAKE_THRESHOLD_RST = 16'h4000;
	localparam logic [7:0] DEF_GAIN = 8'h64;
	localparam logic [7:0] DEF_OVS_RATIO = 8'h40;
	localparam logic [3:0] DEF_CHOP_RATIO = 4'h4;
	localparam logic [10:0] DEF_AVG_COUNT = 11'h001;
	localparam logic [1:0] DEF_OVS_CLK_SEL = 2'h1;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_LOAD = 4'h2,
		ST_DETECT = 4'h4,
		ST_RUN = 4'h8
	} seq_state_t;

	typedef struct packed {
		logic fuse_load_mode;
		logic wake_up_mode;
		logic current_measure_mode;
		logic osc_enable;
	} mode_t;

	typedef struct packed {
		logic [7:0] gain;
		logic [1:0] ovs_clk_sel;
		logic [7:0] oversampling_ratio;
		logic [3:0] chopping_ratio;
		logic [10:0] averaging_count;
		logic [15:0] wake_threshold;
	} meas_cfg_t;

	typedef struct packed {
		logic [2:0] source_route;  // vbat, sensor_input_s, sensor_input_r
		logic [4:0] source_level;
		logic [CFG_W-1:0] channel_a;
		logic [CFG_W-1:0] channel_b;
	} mux_cfg_t;

	typedef struct packed {
		logic we;
		logic [1:0] sel;  // 0 trim, 1 calib, 2 channel a/b/source, 3 gain field
		logic [CAL_W-1:0] data;
	} ser_wr_t;
endpackage

// [rtl/power_on_calibration_loader.sv]
// power-on sequencer: fuse image load, clock detect, mode select, trim ports
// assumes fuse images are stable inputs and serial writes arrive pre-decoded
`timescale 1ns/1ps
`default_nettype none
module power_on_calibration_loader #(
	parameter int unsigned LOAD_PULSES = por_cal_pkg::LOAD_PULSES,
	parameter int unsigned OSC_DIV = por_cal_pkg::OSC_DIV,
	parameter int unsigned DETECT_WINDOW = por_cal_pkg::DETECT_WINDOW
) (
	input wire logic i_clk,                                   // 125 MHz clock
	input wire logic i_rst,                                   // async reset, active high
	input wire logic i_ce,                                    // clock enable
	input wire logic i_supply_low,                            // analog_supply below threshold
	input wire logic i_supply_rise,                           // rise 2.0 V to 3.5 V seen
	input wire logic i_ext_clk,                               // external clock pin
	input wire logic [por_cal_pkg::TRIM_W-1:0] i_stored_trim_image,  // fuse trim
	input wire logic [por_cal_pkg::CAL_W-1:0] i_stored_calib_image,  // fuse calib
	input wire por_cal_pkg::ser_wr_t i_ser_wr,                // decoded serial write
	input wire logic [15:0] i_raw_result,                     // converter result
	output logic o_interrupt_out_n,                           // load pulse train, low active
	output por_cal_pkg::mode_t o_mode,                        // operating mode
	output por_cal_pkg::meas_cfg_t o_meas_cfg,                // measurement defaults
	output por_cal_pkg::mux_cfg_t o_mux_cfg,                  // switch settings
	output logic [por_cal_pkg::TRIM_W-1:0] o_trim_register,   // trims
	output logic [por_cal_pkg::CAL_W-1:0] o_calibration_register, // calibration
	output logic [15:0] o_result,                             // gated result
	output logic o_busy                                       // sequence running
);
	localparam int unsigned PW = $clog2(LOAD_PULSES + 1);
	localparam int unsigned DW = $clog2(OSC_DIV + 1);
	localparam int unsigned WW = $clog2(DETECT_WINDOW + 1);
	localparam int unsigned UW = $clog2(por_cal_pkg::UV_FILTER_CYC + 2);
	localparam logic [UW-1:0] UV_LIM = UW'(por_cal_pkg::UV_FILTER_CYC);

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [1:0] low_sync_q, rise_sync_q, clk_sync_q;
	logic clk_prev_q;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			low_sync_q <= '0;
			rise_sync_q <= '0;
			clk_sync_q <= '0;
			clk_prev_q <= 1'b0;
		end else if (i_ce) begin
			low_sync_q <= {low_sync_q[0], i_supply_low};
			rise_sync_q <= {rise_sync_q[0], i_supply_rise};
			clk_sync_q <= {clk_sync_q[0], i_ext_clk};
			clk_prev_q <= clk_sync_q[1];
		end
	end
	wire logic ext_edge = clk_sync_q[1] & ~clk_prev_q;

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	por_cal_pkg::seq_state_t state_q, state_d;
	logic [UW-1:0] uv_q, uv_d;
	logic [PW-1:0] pulse_q, pulse_d;
	logic [DW-1:0] div_q, div_d;
	logic [WW-1:0] win_q, win_d;
	logic [1:0] edges_q, edges_d;
	logic tick_q, tick_d;
	por_cal_pkg::mode_t mode_q, mode_d;
	logic load_we;
	logic start;

	// filtered undervoltage: one cycle more than 0.5 us of low supply
	assign start = (uv_q == UV_LIM) & low_sync_q[1] | rise_sync_q[1];

	always_comb begin
		state_d = state_q;
		uv_d = low_sync_q[1] ? ((uv_q == UV_LIM) ? uv_q : uv_q + UW'(1)) : '0;
		pulse_d = pulse_q;
		div_d = div_q;
		win_d = win_q;
		edges_d = edges_q;
		tick_d = tick_q;
		mode_d = mode_q;
		load_we = 1'b0;
		case (state_q)
			por_cal_pkg::ST_IDLE: begin
				state_d = por_cal_pkg::ST_LOAD;
			end
			por_cal_pkg::ST_LOAD: begin
				// divider stands in for the slow internal oscillator
				if (div_q == DW'(OSC_DIV - 1)) begin
					div_d = '0;
					tick_d = ~tick_q;
					if (tick_q) begin
						pulse_d = pulse_q + PW'(1);
						if (pulse_q == PW'(LOAD_PULSES - 1)) begin
							load_we = 1'b1;
							state_d = por_cal_pkg::ST_DETECT;
							win_d = '0;
							edges_d = '0;
						end
					end
				end else begin
					div_d = div_q + DW'(1);
				end
			end
			por_cal_pkg::ST_DETECT: begin
				win_d = win_q + WW'(1);
				if (ext_edge && edges_q != 2'h3) begin
					edges_d = edges_q + 2'h1;
				end
				if (win_q == WW'(DETECT_WINDOW - 1)) begin
					state_d = por_cal_pkg::ST_RUN;
					mode_d.fuse_load_mode = 1'b0;
					if (edges_d >= 2'(por_cal_pkg::DETECT_EDGES)) begin
						mode_d.current_measure_mode = 1'b1;
						mode_d.osc_enable = 1'b0;
					end else begin
						mode_d.wake_up_mode = 1'b1;
					end
				end
			end
			por_cal_pkg::ST_RUN: begin
			end
			default: begin
				state_d = por_cal_pkg::ST_IDLE;
			end
		endcase
		if (start) begin
			state_d = por_cal_pkg::ST_LOAD;
			mode_d = '{fuse_load_mode: 1'b1, wake_up_mode: 1'b0,
				current_measure_mode: 1'b0, osc_enable: 1'b1};
			pulse_d = '0;
			div_d = '0;
			tick_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= por_cal_pkg::ST_IDLE;
			uv_q <= '0;
			pulse_q <= '0;
			div_q <= '0;
			win_q <= '0;
			edges_q <= '0;
			tick_q <= 1'b0;
			mode_q <= '{fuse_load_mode: 1'b1, wake_up_mode: 1'b0,
				current_measure_mode: 1'b0, osc_enable: 1'b1};
		end else if (i_ce) begin
			state_q <= state_d;
			uv_q <= uv_d;
			pulse_q <= pulse_d;
			div_q <= div_d;
			win_q <= win_d;
			edges_q <= edges_d;
			tick_q <= tick_d;
			mode_q <= mode_d;
		end
	end

	// ---------------------------------------------------------------
	// working registers
	// ---------------------------------------------------------------
	logic ser_ok;
	logic trim_we, cal_we;
	logic [por_cal_pkg::TRIM_W-1:0] trim_wd;
	logic [por_cal_pkg::CAL_W-1:0] cal_wd;
	// serial writes are held off while loading so the image copy cannot be torn
	assign ser_ok = i_ser_wr.we & (state_q == por_cal_pkg::ST_RUN);

	always_comb begin
		trim_we = load_we | (ser_ok & i_ser_wr.sel == 2'h0);
		trim_wd = load_we ? i_stored_trim_image : i_ser_wr.data[por_cal_pkg::TRIM_W-1:0];
		cal_we = load_we | (ser_ok & (i_ser_wr.sel == 2'h1 | i_ser_wr.sel == 2'h3));
		cal_wd = i_ser_wr.data;
		if (load_we) begin
			cal_wd = i_stored_calib_image;
			cal_wd[por_cal_pkg::G100_LSB +: por_cal_pkg::G100_W] = '0;
		end else if (i_ser_wr.sel == 2'h3) begin
			// gain field only, rest kept: host copies stored factor here
			cal_wd = o_calibration_register;
			cal_wd[por_cal_pkg::G100_LSB +: por_cal_pkg::G100_W] =
				i_ser_wr.data[por_cal_pkg::G100_W-1:0];
		end
	end

	cal_store #(.W(por_cal_pkg::TRIM_W)) u_trim (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_we(trim_we),
		.i_wd(trim_wd),
		.o_rd(o_trim_register)
	);

	cal_store #(.W(por_cal_pkg::CAL_W)) u_cal (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_we(cal_we),
		.i_wd(cal_wd),
		.o_rd(o_calibration_register)
	);

	// ---------------------------------------------------------------
	// mux configuration and result gating
	// ---------------------------------------------------------------
	por_cal_pkg::mux_cfg_t mux_q, mux_d;
	logic [15:0] res_q, res_d;
	always_comb begin
		mux_d = mux_q;
		if (ser_ok && i_ser_wr.sel == 2'h2) begin
			mux_d = i_ser_wr.data[$bits(por_cal_pkg::mux_cfg_t)-1:0];
		end
		res_d = (o_calibration_register[por_cal_pkg::G100_LSB +: por_cal_pkg::G100_W] == '0)
			? 16'h0000 : i_raw_result;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mux_q <= '0;
			res_q <= '0;
		end else if (i_ce) begin
			mux_q <= mux_d;
			res_q <= res_d;
		end
	end

	assign o_mux_cfg = mux_q;
	assign o_result = res_q;
	assign o_mode = mode_q;
	assign o_interrupt_out_n = ~(tick_q & (state_q == por_cal_pkg::ST_LOAD));
	assign o_busy = (state_q != por_cal_pkg::ST_RUN);
	assign o_meas_cfg = '{gain: por_cal_pkg::DEF_GAIN,
		ovs_clk_sel: por_cal_pkg::DEF_OVS_CLK_SEL,
		oversampling_ratio: por_cal_pkg::DEF_OVS_RATIO,
		chopping_ratio: por_cal_pkg::DEF_CHOP_RATIO,
		averaging_count: por_cal_pkg::DEF_AVG_COUNT,
		wake_threshold: por_cal_pkg::WAKE_THRESHOLD_RST};

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_load_done;
		i_ce && load_we;
	endsequence

	a_load_mode_entry: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && start) |=> mode_q.fuse_load_mode && mode_q.osc_enable)
		else $error("sequence start did not select fuse load mode");
	a_osc_on_load: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_q == por_cal_pkg::ST_LOAD) |-> mode_q.osc_enable)
		else $error("oscillator off while loading");
	a_gain_zeroed: assert property (@(posedge i_clk) disable iff (i_rst)
		s_load_done |=>
		o_calibration_register[por_cal_pkg::G100_LSB +: por_cal_pkg::G100_W] == '0)
		else $error("gain factor not zeroed by load");
	a_trim_copied: assert property (@(posedge i_clk) disable iff (i_rst)
		s_load_done |=> o_trim_register == $past(i_stored_trim_image))
		else $error("trim image not copied");
	a_pulse_count: assert property (@(posedge i_clk) disable iff (i_rst)
		s_load_done |-> pulse_q == PW'(LOAD_PULSES - 1))
		else $error("load ended at wrong pulse count");
	a_zero_result: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && o_calibration_register[por_cal_pkg::G100_W-1:0] == '0) |=> o_result == 16'h0000)
		else $error("result not forced to zero");
	a_int_idle_high: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_q != por_cal_pkg::ST_LOAD) |-> o_interrupt_out_n)
		else $error("interrupt pin low outside load");
	a_mode_exclusive: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_q == por_cal_pkg::ST_RUN) |-> (mode_q.wake_up_mode ^ mode_q.current_measure_mode))
		else $error("run state without exactly one mode");
	a_no_write_busy: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && i_ser_wr.we && o_busy && !load_we) |=> $stable(o_trim_register))
		else $error("serial write accepted during sequence");
endmodule
`default_nettype wire

// [test/host_model.sv]
// microcontroller model: serial register writes and the external clock pin
// assumes the bench calls its tasks from a falling clock edge
`timescale 1ns/1ps
`default_nettype none
module host_model #(
	parameter logic [15:0] STORED_G100 = 16'hcdef // default equals the gain field of the bench's stored calib image
) (
	input wire logic i_clk,                // system clock
	input wire logic i_clk_on,             // run the external clock
	output logic o_ext_clk,                // external clock pin
	output por_cal_pkg::ser_wr_t o_ser_wr  // decoded serial write
);
	logic [1:0] div_q;
	initial begin
		o_ext_clk = 1'b0;
		o_ser_wr = '0;
		div_q = 2'h0;
	end
	// ----------------------------------------
	// clock pin stands still when not running
	// ----------------------------------------
	always @(negedge i_clk) begin
		if (i_clk_on) begin
			div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
			if (div_q == 2'h2) o_ext_clk <= ~o_ext_clk;
		end
	end
	// ----------------------------------------
	// register port
	// ----------------------------------------
	task automatic write(input logic [1:0] sel, input logic [63:0] data);
		@(negedge i_clk);
		o_ser_wr.we = 1'b1;
		o_ser_wr.sel = sel;
		o_ser_wr.data = data;
		@(negedge i_clk);
		o_ser_wr.we = 1'b0;
		// released bus shows no stale value
		o_ser_wr.data = ~data;
	endtask
	// copy the stored gain-100 factor into the active slot
	task automatic restore_gain();
		write(2'h3, {48'h0, STORED_G100});
	endtask
endmodule
`default_nettype wire

// [test/power_on_calibration_loader_tb.sv]
// self-checking bench for the power-on calibration loader
// assumes short load counts via parameters; inputs change on falling edges
`timescale 1ns/1ps
`default_nettype none
module power_on_calibration_loader_tb;
	localparam int unsigned NP = 6;
	localparam int unsigned DIV = 2;
	localparam int unsigned WIN = 16;
	localparam logic [31:0] TRIM_IMG = 32'h5a5a_1234;
	localparam logic [63:0] CAL_IMG = 64'h0123_4567_89ab_cdef;
	localparam logic [15:0] RAW = 16'h1234;
	logic clk = 1'b0, rst = 1'b1, clk_on = 1'b0, sup_low = 1'b0, sup_rise = 1'b0;
	logic ce = 1'b1;
	logic ext_clk, int_n, busy;
	por_cal_pkg::ser_wr_t ser_wr;
	por_cal_pkg::mode_t mode;
	por_cal_pkg::meas_cfg_t meas;
	por_cal_pkg::mux_cfg_t mux;
	logic [31:0] trim;
	logic [63:0] cal;
	logic [15:0] res;
	int miscompares = 0, n_compared = 0, cycles = 0;

	always #4 clk = ~clk;

	host_model host (.i_clk(clk), .i_clk_on(clk_on), .o_ext_clk(ext_clk), .o_ser_wr(ser_wr));

	power_on_calibration_loader #(.LOAD_PULSES(NP), .OSC_DIV(DIV), .DETECT_WINDOW(WIN)) dut (
		.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_supply_low(sup_low),
		.i_supply_rise(sup_rise), .i_ext_clk(ext_clk), .i_stored_trim_image(TRIM_IMG),
		.i_stored_calib_image(CAL_IMG), .i_ser_wr(ser_wr), .i_raw_result(RAW),
		.o_interrupt_out_n(int_n), .o_mode(mode), .o_meas_cfg(meas), .o_mux_cfg(mux),
		.o_trim_register(trim), .o_calibration_register(cal), .o_result(res), .o_busy(busy)
	);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic end_of_test();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// counts low cycles of the pulse train until the sequence ends
	task automatic run_seq(output int lows);
		lows = 0;
		for (int i = 0; i < 2000 && busy !== 1'b0; i++) begin
			if (int_n === 1'b0) lows++;
			@(negedge clk);
		end
		chk(busy, 1'b0);
		repeat (2) @(negedge clk);
	endtask
	task automatic do_reset(input logic ext);
		int lows;
		clk_on = ext;
		rst = 1'b1;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		chk(mode, 4'b1001);
		run_seq(lows);
		chk(lows, NP * DIV);
		chk(int_n, 1'b1);
		chk(trim, TRIM_IMG);
		chk(cal, {CAL_IMG[63:16], 16'h0});
		chk(res, 16'h0);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_wake();
		do_reset(1'b0);
		chk(mode, 4'b0101);
		chk(meas.wake_threshold, 16'h4000);
		$display("t_wake done");
	endtask
	task automatic t_meas();
		do_reset(1'b1);
		clk_on = 1'b0;
		chk(mode, 4'b0010);
		chk(meas, {8'h64, 2'h1, 8'h40, 4'h4, 11'h001, 16'h4000});
		$display("t_meas done");
	endtask
	task automatic t_writes();
		logic [2:0] rt;
		host.write(2'h0, 64'h0000_0000_c3a5_0f1e);
		@(negedge clk);
		chk(trim, 32'hc3a5_0f1e);
		// a write strobe seen while the clock enable is low must leave state frozen
		ce = 1'b0;
		host.write(2'h0, 64'h0000_0000_ffff_0000);
		ce = 1'b1;
		@(negedge clk);
		chk(trim, 32'hc3a5_0f1e);
		host.write(2'h1, 64'h1111_2222_3333_0000);
		@(negedge clk);
		chk(cal, 64'h1111_2222_3333_0000);
		for (int i = 0; i < 3; i++) begin
			rt = 3'b001 << i;
			host.write(2'h2, {24'h0, rt, 5'h1f - 5'(i), 16'hbeef, 16'h0042});
			@(negedge clk);
			chk(mux, {rt, 5'h1f - 5'(i), 16'hbeef, 16'h0042});
		end
		chk(res, 16'h0);
		host.restore_gain();
		repeat (2) @(negedge clk);
		chk(cal, 64'h1111_2222_3333_cdef);
		chk(res, RAW);
		$display("t_writes done");
	endtask
	task automatic t_restart();
		int lows;
		// a dip shorter than the filter must not restart
		sup_low = 1'b1;
		repeat (30) @(negedge clk);
		sup_low = 1'b0;
		repeat (5) @(negedge clk);
		chk(busy, 1'b0);
		sup_low = 1'b1;
		repeat (80) @(negedge clk);
		sup_low = 1'b0;
		chk(busy, 1'b1);
		host.write(2'h0, 64'h0000_0000_ffff_ffff);
		@(negedge clk);
		chk(trim, 32'hc3a5_0f1e);
		run_seq(lows);
		chk(trim, TRIM_IMG);
		chk(cal[15:0], 16'h0);
		chk(mode, 4'b0101);
		sup_rise = 1'b1;
		repeat (3) @(negedge clk);
		sup_rise = 1'b0;
		repeat (3) @(negedge clk);
		chk(busy, 1'b1);
		run_seq(lows);
		chk(lows, NP * DIV);
		$display("t_restart done");
	endtask
	// ----------------------------------------
	// main sequence and hang guard
	// ----------------------------------------
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			end_of_test();
		end
	end
	initial begin
		@(negedge clk);
		t_wake();
		t_meas();
		t_writes();
		t_restart();
		end_of_test();
	end
endmodule
`default_nettype wire
